// *** dv/dmem_model.sv ***
// data memory standing behind the stack sequencer
// assumes combinational reads and writes that land on the rising edge of aclk
`timescale 1ns/10ps
module dmem_model
(
  input  wire logic       aclk,
  input  wire logic       mem_we,
  input  wire logic       mem_re,
  input  wire logic [7:0] mem_addr,
  input  wire logic [7:0] mem_wdata,
  output logic      [7:0] mem_rdata
);
  logic [7:0] mem [256];
  logic [7:0] last_ff = 8'h00;
  // outside a read the bus shows the inverse of the last byte, so stale data never matches
  assign mem_rdata = mem_re ? mem[mem_addr] : ~last_ff;
  always_ff @(posedge aclk) begin
    if (mem_we) mem[mem_addr] <= mem_wdata;
    if (mem_re) last_ff <= mem[mem_addr];
  end
endmodule // dmem_model

// *** dv/mcu_interrupt_controller_tb_top.sv ***
// bench of the interrupt controller: registers, edges, entry, return, stack, timer
// assumes the bench plays cpu and software, and dmem_model stands in for data memory
`timescale 1ns/10ps
module mcu_interrupt_controller_tb_top
  import intc_pkg::*;
;
  logic                  aclk = 1'h0, aresetn = 1'h0;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]           s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic                  s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic                  s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic                  port_a_bit0_pin = 1'h0, port_b_bit0_pin = 1'h0, instr_boundary = 1'h1;
  logic [15:0]           pc_in = 16'h0, load_data;
  logic [7:0]            working_register = 8'h0, cpu_flags = 8'h0, mem_addr, mem_wdata, mem_rdata;
  logic [4:0]            strb = 5'h0;
  logic                  irq_taken, seq_busy, mem_we, mem_re, pc_load, af_load;
  int                    checked = 0, mismatches = 0, n_irq = 0;
  localparam logic [7:0] RIDX [7] = '{IDX_SP, IDX_CTRL, IDX_LINE_EN, IDX_FLAGS, IDX_TMODE, IDX_TCOUNT, IDX_EDGE};
  localparam logic [1:0] EMODE [4] = '{EDGE_BOTH, EDGE_RISE, EDGE_FALL, 2'h3};

  mcu_interrupt_controller mcu_interrupt_controller_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .port_a_bit0_pin, .port_b_bit0_pin, .timer_src_tick(8'h00), .instr_boundary, .pc_in,
    .working_register, .cpu_flags, .engint_strobe(strb[0]), .disgint_strobe(strb[1]),
    .reti_strobe(strb[2]), .pushaf_strobe(strb[3]), .popaf_strobe(strb[4]), .irq_taken,
    .seq_busy, .mem_we, .mem_re, .mem_addr, .mem_wdata, .mem_rdata, .pc_load, .af_load, .load_data);
  dmem_model dmem_model_inst (.aclk, .mem_we, .mem_re, .mem_addr, .mem_wdata, .mem_rdata);

  always #12.5 aclk = ~aclk;
  always @(posedge aclk) if (irq_taken === 1'h1) n_irq <= n_irq + 1;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // each bus task is entered just after a rising edge
  task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic ta, tw;
    logic [1:0] r;
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end while ((s_axi_awvalid & !ta) | (s_axi_wvalid & !tw));
    do @(negedge aclk); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'h0;
    @(posedge aclk);
    chk(32'(r), 32'(er));
  endtask

  task automatic rd(input logic [7:0] i, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(negedge aclk); while (s_axi_arready !== 1'h1);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'h0;
    @(posedge aclk);
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask

  // strobe order: engint, disgint, reti, pushaf, popaf
  task automatic pulse(input int k);
    strb[k] <= 1'h1;
    @(posedge aclk);
    strb[k] <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic wait_load(input logic [15:0] e, input logic af = 1'h0);
    do @(negedge aclk); while ((pc_load | af_load) !== 1'h1);
    chk(32'(load_data), 32'(e));
    chk(32'(af_load), 32'(af));
    @(posedge aclk);
  endtask

  task automatic t_reset;
    for (int k = 0; k < 7; k++) rd(RIDX[k], 32'h0);
    rd(8'h01, 32'h0, RESP_SLVERR);
    wr(8'h01, 32'hff, RESP_SLVERR);
    $display("reset test done");
  endtask

  task automatic t_edges;
    logic [1:0] m;
    for (int k = 0; k < 4; k++) begin
      m = EMODE[k];
      wr(IDX_EDGE, {28'h0, m, m});
      wr(IDX_FLAGS, 32'h0);
      port_a_bit0_pin <= 1'h1;
      port_b_bit0_pin <= 1'h1;
      cyc(3);
      rd(IDX_FLAGS, (m != EDGE_FALL) ? 32'h3 : 32'h0);
      wr(IDX_FLAGS, 32'h0);
      port_a_bit0_pin <= 1'h0;
      port_b_bit0_pin <= 1'h0;
      cyc(3);
      rd(IDX_FLAGS, (m != EDGE_RISE) ? 32'h3 : 32'h0);
    end
    wr(IDX_FLAGS, 32'h0);
    $display("edge test done");
  endtask

  task automatic t_entry;
    wr(IDX_SP, 32'h10);
    pulse(0);
    rd(IDX_CTRL, 32'h1);
    port_b_bit0_pin <= 1'h1;
    cyc(6);
    chk(32'(n_irq), 32'h0);
    rd(IDX_FLAGS, 32'h2);
    pc_in <= 16'h1234;
    instr_boundary <= 1'h0;
    wr(IDX_LINE_EN, 32'h2);
    cyc(4);
    chk(32'(n_irq), 32'h0);
    instr_boundary <= 1'h1;
    wait_load(VECTOR_ADDR);
    chk(32'(n_irq), 32'h1);
    chk(32'(dmem_model_inst.mem[8'h10]), 32'h34);
    chk(32'(dmem_model_inst.mem[8'h11]), 32'h12);
    rd(IDX_SP, 32'h12);
    rd(IDX_CTRL, 32'h0);
    rd(IDX_FLAGS, 32'h2);
    wr(IDX_FLAGS, 32'h5);
    rd(IDX_FLAGS, 32'h0);
    $display("entry test done");
  endtask

  task automatic t_return;
    pulse(2);
    @(negedge aclk);
    chk(32'(seq_busy), 32'h1);
    wait_load(16'h1234);
    rd(IDX_SP, 32'h10);
    rd(IDX_CTRL, 32'h1);
    $display("return test done");
  endtask

  task automatic t_stack;
    working_register <= 8'h5a;
    cpu_flags <= 8'ha5;
    pulse(3);
    cyc(4);
    chk(32'(dmem_model_inst.mem[8'h10]), 32'h5a);
    chk(32'(dmem_model_inst.mem[8'h11]), 32'ha5);
    rd(IDX_SP, 32'h12);
    pulse(4);
    wait_load(16'ha55a, 1'h1);
    rd(IDX_SP, 32'h10);
    rd(IDX_CTRL, 32'h1);
    pulse(1);
    rd(IDX_CTRL, 32'h0);
    $display("stack test done");
  endtask

  task automatic t_timer;
    for (int k = 0; k < 3; k++) begin
      wr(IDX_TMODE, {24'h0, TSRC_SYSCLK, (k < 2) ? 2'h1 : 2'h0, 3'h0});
      wr(IDX_EDGE, {27'h0, k != 0, 4'hf});
      wr(IDX_TCOUNT, {23'h0, k != 0, 8'h00});
      wr(IDX_FLAGS, 32'h0);
      cyc((k < 2) ? 964 : 200);
      rd(IDX_FLAGS, 32'h0);
      cyc(80);
      rd(IDX_FLAGS, 32'h4);
    end
    $display("timer test done");
  endtask

  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_edges();
    t_entry();
    t_return();
    t_stack();
    t_timer();
    aresetn <= 1'h0;
    cyc(3);
    aresetn <= 1'h1;
    t_reset();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    give_verdict();
  end
endmodule // mcu_interrupt_controller_tb_top

// *** src/edge_sense.sv ***
// one request edge detector with selectable polarity
// assumes the input is synchronous to aclk
`timescale 1ns/10ps
module edge_sense
  import intc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       sig,
  input  wire logic [1:0] mode,
  output logic            hit
);
  logic prev_ff;
  logic nxt_prev;

  always_comb begin
    nxt_prev = sig;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_ff <= sig; // no false edge when the pin rests high at reset release
    end else begin
      prev_ff <= nxt_prev;
    end
  end

  always_comb begin
    if (mode == EDGE_RISE) begin
      hit = sig & ~prev_ff; // [R4]
    end else if (mode == EDGE_FALL) begin
      hit = ~sig & prev_ff; // [R4]
    end else begin
      hit = sig ^ prev_ff; // [R4]
    end
  end

  rise_hit_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    (mode == EDGE_RISE && $rose(sig)) |-> hit) else $error("rising edge missed");
  fall_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    (mode == EDGE_FALL && $rose(sig)) |-> !hit) else $error("falling mode hit on rise");
endmodule // edge_sense

// *** src/intc_pkg.sv ***
// constants, register map and types of the three-line interrupt controller
// assumes one system clock and a cpu sequencer that issues one operation at a time
// Operation
// R1 - three sources: port a bit 0, port b bit 0, timer
// R2 - each source has an enable bit; disabled sources never raise an interrupt
// R3 - hardware sets request flags; software clears them by writing; hardware never clears
// R4 - flags set on rising, falling or both edges per edge selection register
// R5 - global enable set by enable-global, cleared by disable-global instruction
// R6 - software keeps stack pointer bit 0 at zero
// R7 - on entry program counter written at stack pointer, then pointer plus two
// R8 - on entry global enable cleared and fetch continues at vector 0x010
// R9 - return lowers pointer by two and reloads program counter from stack
// R10 - return sets global enable again
// R11 - request flag register readable during service
// R12 - push and pop save and restore working register and flags on stack
// R13 - software reserves two stack bytes per nesting level
// R14 - software clears only the serviced flag bit
// R15 - timer clock is source divided by 1, 4, 16 or 64 per mode bits 4:3
// R16 - free running timer request recurs at prescaled rate over two to n+1
// R17 - timer request comes from one selectable counter bit 8 to 15
// R18 - timer edge chosen by bit 4 of edge selection register
// R19 - interrupt taken only at instruction boundary with enabled flag and global enable
// R20 - reset clears flags, enables and global enable
package intc_pkg;
  localparam int          AXI_ADDR_W   = 10;
  localparam int          NUM_SRC      = 3;
  // register indices; the byte address is four times the index
  localparam logic [7:0]  IDX_SP       = 8'h02;
  localparam logic [7:0]  IDX_CTRL     = 8'h03;
  localparam logic [7:0]  IDX_LINE_EN  = 8'h04;
  localparam logic [7:0]  IDX_FLAGS    = 8'h05;
  localparam logic [7:0]  IDX_TMODE    = 8'h06;
  localparam logic [7:0]  IDX_TCOUNT   = 8'h07;
  localparam logic [7:0]  IDX_EDGE     = 8'h0c;
  // field positions
  localparam int          FLAG_PORT_A  = 0;
  localparam int          FLAG_PORT_B  = 1;
  localparam int          FLAG_T16     = 2;
  localparam int          EDGE_PORT_A_LO = 0;
  localparam int          EDGE_PORT_B_LO = 2;
  localparam int          EDGE_T16_BIT = 4;
  localparam int          TM_BIT_LO    = 0;
  localparam int          TM_PRE_LO    = 3;
  localparam int          TM_SRC_LO    = 5;
  localparam int          TM_BIT_BASE  = 8;
  // reset values
  localparam logic [7:0]  RST_SP       = 8'h00;
  localparam logic [7:0]  RST_TMODE    = 8'h00;
  localparam logic [7:0]  RST_EDGE     = 8'h00;
  localparam logic [2:0]  RST_LINE_EN  = 3'h0;
  localparam logic [2:0]  RST_FLAGS    = 3'h0;
  // edge modes
  localparam logic [1:0]  EDGE_BOTH    = 2'h0;
  localparam logic [1:0]  EDGE_RISE    = 2'h1;
  localparam logic [1:0]  EDGE_FALL    = 2'h2;
  // timer clock sources
  localparam logic [2:0]  TSRC_STOP    = 3'h0;
  localparam logic [2:0]  TSRC_SYSCLK  = 3'h1;
  localparam logic [2:0]  TSRC_PORT_A  = 3'h7;
  localparam logic [15:0] VECTOR_ADDR  = 16'h0010;
  localparam logic [7:0]  SP_STEP      = 8'h02;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  typedef enum logic [2:0] {
    S_IDLE,
    S_PUSH_LO,
    S_PUSH_HI,
    S_POP_HI,
    S_POP_LO
  } seq_state_t;
endpackage

// *** src/mcu_interrupt_controller.sv ***
// interrupt controller with timer, stack sequencer and axi4-lite register slave
// assumes the cpu pulses instruction strobes only at instruction boundaries, one at a time,
// and that the data memory accepts a write or returns read data in the same cycle
`timescale 1ns/10ps
module mcu_interrupt_controller
  import intc_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  port_a_bit0_pin,
  input  wire logic                  port_b_bit0_pin,
  input  wire logic [7:0]            timer_src_tick,
  input  wire logic                  instr_boundary,
  input  wire logic [15:0]           pc_in,
  input  wire logic [7:0]            working_register,
  input  wire logic [7:0]            cpu_flags,
  input  wire logic                  engint_strobe,
  input  wire logic                  disgint_strobe,
  input  wire logic                  reti_strobe,
  input  wire logic                  pushaf_strobe,
  input  wire logic                  popaf_strobe,
  output logic                       irq_taken,
  output logic                       seq_busy,
  output logic                       mem_we,
  output logic                       mem_re,
  output logic [7:0]                 mem_addr,
  output logic [7:0]                 mem_wdata,
  input  wire logic [7:0]            mem_rdata,
  output logic                       pc_load,
  output logic                       af_load,
  output logic [15:0]                load_data
);
  logic                  aw_have_ff, w_have_ff, bvalid_ff, rvalid_ff;
  logic [1:0]            bresp_ff, rresp_ff;
  logic [31:0]           rdata_ff, wdata_ff;
  logic [3:0]            wstrb_ff;
  logic [7:0]            waddr_ff;
  logic                  nxt_aw_have, nxt_w_have, nxt_bvalid, nxt_rvalid;
  logic [1:0]            nxt_bresp, nxt_rresp;
  logic [31:0]           nxt_rdata, nxt_wdata;
  logic [3:0]            nxt_wstrb;
  logic [7:0]            nxt_waddr, raddr_idx;
  logic                  wr_go, wr_hit;
  logic [7:0]            sp_ff, tmode_ff, edge_ff, nxt_sp, nxt_tmode, nxt_edge;
  logic [2:0]            line_en_ff, flags_ff, nxt_line_en, nxt_flags, flag_set, flag_clr;
  logic                  gie_ff, nxt_gie;
  logic [5:0]            pre_ff, nxt_pre, pre_mask;
  logic [15:0]           cnt_ff, nxt_cnt;
  logic                  port_a_prev_ff, nxt_port_a_prev, src_tick, cnt_inc;
  logic [NUM_SRC-1:0]    src_sig;
  logic [2*NUM_SRC-1:0]  src_mode;
  seq_state_t            state_ff, nxt_state;
  logic                  op_af_ff, nxt_op_af, take, reti_done;
  logic [15:0]           data_ff, nxt_data, load_data_ff, nxt_load_data;
  logic                  pc_load_ff, af_load_ff, nxt_pc_load, nxt_af_load;

  // ---------------- axi4-lite slave ----------------
  assign s_axi_awready = !aw_have_ff && !bvalid_ff;
  assign s_axi_wready  = !w_have_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;
  assign wr_go         = aw_have_ff && w_have_ff;
  assign raddr_idx     = s_axi_araddr[AXI_ADDR_W-1:2];

  always_comb begin
    wr_hit = (waddr_ff == IDX_SP) || (waddr_ff == IDX_CTRL) || (waddr_ff == IDX_LINE_EN) ||
             (waddr_ff == IDX_FLAGS) || (waddr_ff == IDX_TMODE) || (waddr_ff == IDX_TCOUNT) ||
             (waddr_ff == IDX_EDGE);
    nxt_aw_have = aw_have_ff;
    nxt_w_have  = w_have_ff;
    nxt_waddr   = waddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_have = 1'b1;
      nxt_waddr   = s_axi_awaddr[AXI_ADDR_W-1:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_have = 1'b1;
      nxt_wdata  = s_axi_wdata;
      nxt_wstrb  = s_axi_wstrb;
    end
    if (wr_go) begin
      nxt_aw_have = 1'b0;
      nxt_w_have  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = RESP_OKAY;
      nxt_rdata  = 32'h0000_0000;
      if (raddr_idx == IDX_SP) begin
        nxt_rdata[7:0] = sp_ff;
      end else if (raddr_idx == IDX_CTRL) begin
        nxt_rdata[1:0] = {seq_busy, gie_ff};
      end else if (raddr_idx == IDX_LINE_EN) begin
        nxt_rdata[2:0] = line_en_ff;
      end else if (raddr_idx == IDX_FLAGS) begin
        nxt_rdata[2:0] = flags_ff; // [R11]
      end else if (raddr_idx == IDX_TMODE) begin
        nxt_rdata[7:0] = tmode_ff;
      end else if (raddr_idx == IDX_TCOUNT) begin
        nxt_rdata[15:0] = cnt_ff;
      end else if (raddr_idx == IDX_EDGE) begin
        nxt_rdata[7:0] = edge_ff;
      end else begin
        nxt_rresp = RESP_SLVERR;
      end
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      waddr_ff   <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= RESP_OKAY;
    end else begin
      aw_have_ff <= nxt_aw_have;
      w_have_ff  <= nxt_w_have;
      waddr_ff   <= nxt_waddr;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  // ---------------- request sources ----------------
  assign src_sig  = {cnt_ff[TM_BIT_BASE + int'(tmode_ff[TM_BIT_LO +: 3])], port_b_bit0_pin, // [R17]
                     port_a_bit0_pin}; // [R1]
  assign src_mode = {edge_ff[EDGE_T16_BIT] ? EDGE_FALL : EDGE_RISE, // [R18]
                     edge_ff[EDGE_PORT_B_LO +: 2], edge_ff[EDGE_PORT_A_LO +: 2]};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
      edge_sense u_edge (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sig     (src_sig[gi]),
        .mode    (src_mode[2*gi +: 2]),
        .hit     (flag_set[gi])
      );
    end
  endgenerate

  // ---------------- timer ----------------
  always_comb begin
    nxt_port_a_prev = port_a_bit0_pin;
    case (tmode_ff[TM_SRC_LO +: 3])
      TSRC_STOP:   src_tick = 1'b0;
      TSRC_SYSCLK: src_tick = 1'b1;
      TSRC_PORT_A: src_tick = port_a_bit0_pin & ~port_a_prev_ff;
      default:     src_tick = timer_src_tick[tmode_ff[TM_SRC_LO +: 3]];
    endcase
    case (tmode_ff[TM_PRE_LO +: 2])
      2'h0:    pre_mask = 6'h00;
      2'h1:    pre_mask = 6'h03;
      2'h2:    pre_mask = 6'h0f;
      default: pre_mask = 6'h3f;
    endcase
    cnt_inc = src_tick && ((pre_ff & pre_mask) == pre_mask); // [R15]
    nxt_pre = src_tick ? pre_ff + 6'h01 : pre_ff;
    nxt_cnt = cnt_inc ? cnt_ff + 16'h0001 : cnt_ff; // [R16]
    if (wr_go && waddr_ff == IDX_TCOUNT) begin
      if (wstrb_ff[0]) nxt_cnt[7:0] = wdata_ff[7:0];
      if (wstrb_ff[1]) nxt_cnt[15:8] = wdata_ff[15:8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_ff         <= 6'h00;
      cnt_ff         <= 16'h0000;
      port_a_prev_ff <= port_a_bit0_pin;
    end else begin
      pre_ff         <= nxt_pre;
      cnt_ff         <= nxt_cnt;
      port_a_prev_ff <= nxt_port_a_prev;
    end
  end

  // ---------------- control registers ----------------
  assign take      = (state_ff == S_IDLE) && instr_boundary && gie_ff && |(flags_ff & line_en_ff); // [R19] [R2]
  assign reti_done = (state_ff == S_POP_LO) && !op_af_ff;

  always_comb begin
    nxt_line_en = line_en_ff;
    nxt_tmode   = tmode_ff;
    nxt_edge    = edge_ff;
    flag_clr    = 3'h0;
    if (wr_go && wstrb_ff[0]) begin
      if (waddr_ff == IDX_LINE_EN) nxt_line_en = wdata_ff[2:0];
      if (waddr_ff == IDX_TMODE) nxt_tmode = wdata_ff[7:0];
      if (waddr_ff == IDX_EDGE) nxt_edge = wdata_ff[7:0];
      if (waddr_ff == IDX_FLAGS) flag_clr = ~wdata_ff[2:0];
    end
    nxt_flags = (flags_ff & ~flag_clr) | flag_set; // [R3]
    if (take) begin
      nxt_gie = 1'b0; // [R8]
    end else if (reti_done) begin
      nxt_gie = 1'b1; // [R10]
    end else if (engint_strobe) begin
      nxt_gie = 1'b1; // [R5]
    end else if (disgint_strobe) begin
      nxt_gie = 1'b0; // [R5]
    end else begin
      nxt_gie = gie_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_en_ff <= RST_LINE_EN; // [R20]
      flags_ff   <= RST_FLAGS;   // [R20]
      gie_ff     <= 1'b0;        // [R20]
      tmode_ff   <= RST_TMODE;
      edge_ff    <= RST_EDGE;
    end else begin
      line_en_ff <= nxt_line_en;
      flags_ff   <= nxt_flags;
      gie_ff     <= nxt_gie;
      tmode_ff   <= nxt_tmode;
      edge_ff    <= nxt_edge;
    end
  end

  // ---------------- stack sequencer ----------------
  assign seq_busy  = state_ff != S_IDLE;
  assign irq_taken = take;
  assign pc_load   = pc_load_ff;
  assign af_load   = af_load_ff;
  assign load_data = load_data_ff;

  always_comb begin
    nxt_state     = state_ff;
    nxt_op_af     = op_af_ff;
    nxt_data      = data_ff;
    nxt_load_data = load_data_ff;
    nxt_pc_load   = 1'b0;
    nxt_af_load   = 1'b0;
    nxt_sp        = (wr_go && wstrb_ff[0] && waddr_ff == IDX_SP) ? wdata_ff[7:0] : sp_ff;
    mem_we        = 1'b0;
    mem_re        = 1'b0;
    mem_addr      = sp_ff;
    mem_wdata     = data_ff[7:0];
    case (state_ff)
      S_IDLE: begin
        if (take) begin
          nxt_state = S_PUSH_LO;
          nxt_op_af = 1'b0;
          nxt_data  = pc_in;
        end else if (pushaf_strobe) begin
          nxt_state = S_PUSH_LO;
          nxt_op_af = 1'b1;
          nxt_data  = {cpu_flags, working_register}; // [R12]
        end else if (reti_strobe || popaf_strobe) begin
          nxt_state = S_POP_HI;
          nxt_op_af = popaf_strobe;
        end
      end
      S_PUSH_LO: begin
        mem_we    = 1'b1; // [R7]
        nxt_state = S_PUSH_HI;
      end
      S_PUSH_HI: begin
        mem_we    = 1'b1;
        mem_addr  = sp_ff + 8'h01;
        mem_wdata = data_ff[15:8];
        nxt_sp    = sp_ff + SP_STEP; // [R7]
        nxt_state = S_IDLE;
        if (!op_af_ff) begin
          nxt_pc_load   = 1'b1;
          nxt_load_data = VECTOR_ADDR; // [R8]
        end
      end
      S_POP_HI: begin
        mem_re        = 1'b1;
        mem_addr      = sp_ff - 8'h01;
        nxt_data[15:8] = mem_rdata;
        nxt_state     = S_POP_LO;
      end
      S_POP_LO: begin
        mem_re        = 1'b1;
        mem_addr      = sp_ff - SP_STEP;
        nxt_sp        = sp_ff - SP_STEP; // [R9]
        nxt_load_data = {data_ff[15:8], mem_rdata}; // [R9] [R12]
        nxt_pc_load   = !op_af_ff;
        nxt_af_load   = op_af_ff;
        nxt_state     = S_IDLE;
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff     <= S_IDLE;
      op_af_ff     <= 1'b0;
      data_ff      <= 16'h0000;
      load_data_ff <= 16'h0000;
      pc_load_ff   <= 1'b0;
      af_load_ff   <= 1'b0;
      sp_ff        <= RST_SP;
    end else begin
      state_ff     <= nxt_state;
      op_af_ff     <= nxt_op_af;
      data_ff      <= nxt_data;
      load_data_ff <= nxt_load_data;
      pc_load_ff   <= nxt_pc_load;
      af_load_ff   <= nxt_af_load;
      sp_ff        <= nxt_sp;
    end
  end

  // ---------------- checks ----------------
  sequence push_pc_s;
    mem_we && mem_addr == $past(sp_ff) ##1 mem_we && mem_addr == $past(sp_ff) + 8'h01;
  endsequence

  take_gated_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R19]
    take |-> gie_ff && instr_boundary && (flags_ff & line_en_ff) != 3'h0) else $error("take without cause");
  line_enable_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    (line_en_ff == 3'h0) |-> !take) else $error("disabled line raised interrupt");
  flag_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    (flags_ff[FLAG_PORT_A] && !(wr_go && waddr_ff == IDX_FLAGS)) |=> flags_ff[FLAG_PORT_A])
    else $error("flag dropped without software clear");
  take_gie_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
    take |=> !gie_ff) else $error("global enable kept on entry");
  push_store_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    take |=> push_pc_s ##1 sp_ff == $past(sp_ff, 3) + SP_STEP) else $error("pc push wrong");
  vector_fetch_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
    take |-> ##3 pc_load && load_data == VECTOR_ADDR) else $error("vector not loaded");
  reti_pop_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
    (state_ff == S_IDLE && reti_strobe && !take && !pushaf_strobe && !popaf_strobe)
    |-> ##3 pc_load && sp_ff == $past(sp_ff, 3) - SP_STEP) else $error("return pop wrong");
  reti_gie_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
    reti_done |=> gie_ff) else $error("return left global enable off");
  engint_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
    (engint_strobe && !take && !reti_done) |=> gie_ff) else $error("enable-global ignored");
  timer_stop_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
    (tmode_ff[TM_SRC_LO +: 3] == TSRC_STOP && !(wr_go && waddr_ff == IDX_TCOUNT)) |=> $stable(cnt_ff))
    else $error("stopped timer moved");
endmodule // mcu_interrupt_controller
